// [hw/cpsc_regs.svh]
// register offsets, field positions and reset values of the card power switch control
`ifndef CPSC_REGS_SVH
`define CPSC_REGS_SVH

// ==========================================================
// register byte offsets
`define CPSC_OFS_CTRL 8'h00
`define CPSC_OFS_STATUS 8'h04
`define CPSC_OFS_WORD 8'h08
`define CPSC_OFS_SHIFT 8'h0C
`define CPSC_OFS_LEVELS 8'h10
`define CPSC_OFS_PROT 8'h14
`define CPSC_OFS_LATCHES 8'h18

// ==========================================================
// control register fields and reset value
`define CPSC_CTRL_SOFT_RESET 0
`define CPSC_CTRL_LOW_POWER_LIMIT_N_OC_EN 1
`define CPSC_CTRL_RST 2'h2

// ==========================================================
// control word bit positions
`define CPSC_WORD_W 11
`define CPSC_WORD_RST 11'h000
`define CPSC_D_A_PRG0 0
`define CPSC_D_A_PRG1 1
`define CPSC_D_A_PRI3 2
`define CPSC_D_A_PRI5 3
`define CPSC_D_B_PRG0 4
`define CPSC_D_B_PRG1 5
`define CPSC_D_B_PRI5 6
`define CPSC_D_B_PRI3 7
`define CPSC_D_PWR 8
`define CPSC_D_A_PRG5 9
`define CPSC_D_B_PRG5 10

// ==========================================================
// pin synchroniser width and reset image (active-low pins idle high)
`define CPSC_PIN_W 12
`define CPSC_PIN_INIT 12'h030

`endif

// [hw/cpsc_pkg.sv]
// types shared by the card power switch control
package cpsc_pkg;

  // level presented on one switched supply output
  typedef enum logic [2:0] {
    LVL_HIZ = 3'h0,
    LVL_GND = 3'h1,
    LVL_V33 = 3'h2,
    LVL_V5 = 3'h3,
    LVL_V12 = 3'h4,
    LVL_DISCH = 3'h5
  } cpsc_level_e;

  // gray along discharge -> armed -> run
  typedef enum logic [1:0] {
    ST_DISCH = 2'h0,
    ST_ARMED = 2'h1,
    ST_RUN = 2'h3
  } cpsc_state_e;

endpackage

// [hw/cpsc_sync.sv]
// two-flop pin synchroniser with rising edge detect
`timescale 1ns/10ps
`default_nettype none
module cpsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins
  input wire logic [W-1:0] async_in,
  // synchronised view
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // meta_q feeds sync_q only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
      prev_q <= INIT;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
endmodule
`default_nettype wire

// [hw/cpsc_top.sv]
// card power switch control: serial word, reset discharge, protection, ahb status
`timescale 1ns/10ps
`default_nettype none
`include "cpsc_regs.svh"
module cpsc_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial control link
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic serial_latch,
  // reset, standby and mode pins
  input wire logic reset_hi,
  input wire logic reset_pin_n,
  input wire logic low_power_limit_n,
  input wire logic mode_sel,
  // protection sensing
  input wire logic [3:0] overload_sense,
  input wire logic overtemp,
  // switched supplies
  output var cpsc_pkg::cpsc_level_e slot_a_primary_supply,
  output var cpsc_pkg::cpsc_level_e slot_a_program_supply,
  output var cpsc_pkg::cpsc_level_e slot_b_primary_supply,
  output var cpsc_pkg::cpsc_level_e slot_b_program_supply,
  // ground discharge switches
  output logic discharge_switch_one,
  output logic discharge_switch_four,
  output logic discharge_switch_seven,
  output logic discharge_switch_eleven,
  // protection outputs
  output logic [3:0] current_limit_on,
  output logic reduced_limit,
  output logic overload_flag_n
);
  import cpsc_pkg::*;

  // ==========================================================
  // decode helpers

  // sel is {5v bit, 3.3v bit}; both or neither give 0 V
  function automatic cpsc_level_e primary_lvl(input logic [1:0] sel);
    cpsc_level_e l;
    l = LVL_GND;
    unique case (sel)
      2'b01: l = LVL_V33;
      2'b10: l = LVL_V5;
      default: l = LVL_GND;
    endcase
    return l;
  endfunction

  // sel is {prg0, prg1}
  function automatic cpsc_level_e program_lvl(
    input logic [1:0] sel,
    input logic hi5,
    input logic indep,
    input cpsc_level_e prim
  );
    cpsc_level_e l;
    l = LVL_GND;
    unique case (sel)
      2'b00: l = LVL_GND;
      2'b01: l = indep ? (hi5 ? LVL_V5 : LVL_V33) : prim;
      2'b10: l = LVL_V12;
      2'b11: l = LVL_HIZ;
    endcase
    return l;
  endfunction

  // discharge overrides everything, then power-down and overtemperature
  function automatic cpsc_level_e gate_lvl(
    input cpsc_level_e l,
    input logic run,
    input logic off
  );
    cpsc_level_e g;
    g = l;
    if (!run)
      g = LVL_DISCH;
    else if (off)
      g = LVL_HIZ;
    return g;
  endfunction

  function automatic logic powered(input cpsc_level_e l);
    return (l == LVL_V33) || (l == LVL_V5) || (l == LVL_V12);
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [`CPSC_PIN_W-1:0] pin_raw;
  logic [`CPSC_PIN_W-1:0] pin_lvl;
  logic [`CPSC_PIN_W-1:0] pin_rise;

  assign pin_raw = {overload_sense, overtemp, mode_sel, low_power_limit_n,
                    reset_pin_n, reset_hi, serial_latch, serial_data, serial_clk};

  cpsc_sync #(
    .W(`CPSC_PIN_W),
    .INIT(`CPSC_PIN_INIT)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(pin_raw),
    .level(pin_lvl),
    .rise(pin_rise)
  );

  logic sclk_rise;
  logic sdata;
  logic latch_rise;
  logic rst_hi_s;
  logic rst_n_s;
  logic standby;
  logic indep_mode;
  logic hot;
  logic [3:0] ovl_s;

  assign sclk_rise = pin_rise[0];
  assign sdata = pin_lvl[1];
  assign latch_rise = pin_rise[2];
  assign rst_hi_s = pin_lvl[3];
  assign rst_n_s = pin_lvl[4];
  assign standby = ~pin_lvl[5];
  assign indep_mode = pin_lvl[6];
  assign hot = pin_lvl[7];
  assign ovl_s = pin_lvl[11:8];

  // ==========================================================
  // control register state
  logic [1:0] ctrl_q;
  logic reset_any;
  logic latch_ok;

  // open reset pins are pulled to their idle level outside this logic
  assign reset_any = rst_hi_s | ~rst_n_s | ctrl_q[`CPSC_CTRL_SOFT_RESET];
  assign latch_ok = latch_rise & ~reset_any;

  // ==========================================================
  // serial shift and latch
  logic [`CPSC_WORD_W-1:0] shift_q;
  logic [`CPSC_WORD_W-1:0] word_q;
  logic [3:0] bits_q;
  logic short_q;
  logic [7:0] latches_q;

  // first bit clocked ends in D10, last in D0
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      shift_q <= `CPSC_WORD_RST;
    else if (sclk_rise)
      shift_q <= {shift_q[`CPSC_WORD_W-2:0], sdata};
  end

  // a latch in the same cycle as a clock edge takes the word before that shift
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      word_q <= `CPSC_WORD_RST;
    else if (latch_ok)
      word_q <= shift_q;
  end

  // bits since the last latch, saturating; short words are still taken
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bits_q <= 4'h0;
      short_q <= 1'b0;
      latches_q <= 8'h00;
    end
    else if (latch_ok)
    begin
      bits_q <= 4'h0;
      short_q <= (bits_q < 4'hB);
      latches_q <= latches_q + 8'h01;
    end
    else if (sclk_rise && bits_q != 4'hF)
      bits_q <= bits_q + 4'h1;
  end

  // ==========================================================
  // discharge / run sequencing
  cpsc_state_e state_q;
  cpsc_state_e state_d;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_DISCH: state_d = reset_any ? ST_DISCH : ST_ARMED;
      ST_ARMED: state_d = reset_any ? ST_DISCH : (latch_ok ? ST_RUN : ST_ARMED);
      ST_RUN: state_d = reset_any ? ST_DISCH : ST_RUN;
      default: state_d = ST_DISCH;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_q <= ST_DISCH;
    else
      state_q <= state_d;
  end

  // ==========================================================
  // output decode
  logic run;
  logic off;
  cpsc_level_e a_pri;
  cpsc_level_e b_pri;
  cpsc_level_e a_prg;
  cpsc_level_e b_prg;
  cpsc_level_e a_pri_g;
  cpsc_level_e b_pri_g;
  cpsc_level_e a_prg_g;
  cpsc_level_e b_prg_g;

  assign run = (state_q == ST_RUN);
  assign off = ~word_q[`CPSC_D_PWR] | hot;
  assign a_pri = primary_lvl({word_q[`CPSC_D_A_PRI5], word_q[`CPSC_D_A_PRI3]});
  assign b_pri = primary_lvl({word_q[`CPSC_D_B_PRI5], word_q[`CPSC_D_B_PRI3]});
  assign a_prg = program_lvl({word_q[`CPSC_D_A_PRG0], word_q[`CPSC_D_A_PRG1]},
                             word_q[`CPSC_D_A_PRG5], indep_mode, a_pri);
  assign b_prg = program_lvl({word_q[`CPSC_D_B_PRG0], word_q[`CPSC_D_B_PRG1]},
                             word_q[`CPSC_D_B_PRG5], indep_mode, b_pri);
  assign a_pri_g = gate_lvl(a_pri, run, off);
  assign b_pri_g = gate_lvl(b_pri, run, off);
  assign a_prg_g = gate_lvl(a_prg, run, off);
  assign b_prg_g = gate_lvl(b_prg, run, off);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slot_a_primary_supply <= LVL_DISCH;
      slot_a_program_supply <= LVL_DISCH;
      slot_b_primary_supply <= LVL_DISCH;
      slot_b_program_supply <= LVL_DISCH;
      discharge_switch_one <= 1'b1;
      discharge_switch_four <= 1'b1;
      discharge_switch_seven <= 1'b1;
      discharge_switch_eleven <= 1'b1;
    end
    else
    begin
      slot_a_primary_supply <= a_pri_g;
      slot_a_program_supply <= a_prg_g;
      slot_b_primary_supply <= b_pri_g;
      slot_b_program_supply <= b_prg_g;
      discharge_switch_one <= ~run;
      discharge_switch_four <= ~run;
      discharge_switch_seven <= ~run;
      discharge_switch_eleven <= ~run;
    end
  end

  // ==========================================================
  // protection
  logic [3:0] out_on;
  logic [3:0] limit_d;
  logic low_power_limit_n_oc_q;

  // order: a primary, a program, b primary, b program
  assign out_on = {powered(b_prg_g), powered(b_pri_g), powered(a_prg_g), powered(a_pri_g)};
  assign limit_d = ovl_s & out_on;

  // resettles while standby lasts; set wins over the standby-exit clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_power_limit_n_oc_q <= 1'b0;
    else if (latch_ok && standby && ctrl_q[`CPSC_CTRL_LOW_POWER_LIMIT_N_OC_EN])
      low_power_limit_n_oc_q <= 1'b1;
    else if (!standby)
      low_power_limit_n_oc_q <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      current_limit_on <= 4'h0;
      reduced_limit <= 1'b0;
      overload_flag_n <= 1'b1;
    end
    else
    begin
      current_limit_on <= limit_d;
      reduced_limit <= standby;
      overload_flag_n <= ~((|limit_d) | hot | low_power_limit_n_oc_q);
    end
  end

  // ==========================================================
  // ahb-lite slave, zero wait states
  logic ap_take;
  logic ap_word;
  logic dp_we_q;
  logic [7:0] dp_addr_q;
  logic [31:0] rd_mux;
  logic [31:0] status_w;
  logic [31:0] levels_w;

  assign ap_take = hsel & htrans[1] & hready;
  assign ap_word = (hsize == 3'h2);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_we_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end
    else
    begin
      dp_we_q <= ap_take & hwrite & ap_word;
      if (ap_take)
        dp_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= `CPSC_CTRL_RST;
    else if (dp_we_q && dp_addr_q == `CPSC_OFS_CTRL)
      ctrl_q <= hwdata[1:0];
  end

  assign status_w = {19'h0, bits_q, short_q, low_power_limit_n_oc_q, reset_any, indep_mode,
                     standby, hot, ~overload_flag_n, state_q};
  assign levels_w = {20'h0, slot_b_program_supply, slot_b_primary_supply,
                     slot_a_program_supply, slot_a_primary_supply};

  assign rd_mux =
    (haddr[7:0] == `CPSC_OFS_CTRL) ? {30'h0, ctrl_q} :
    (haddr[7:0] == `CPSC_OFS_STATUS) ? status_w :
    (haddr[7:0] == `CPSC_OFS_WORD) ? {21'h0, word_q} :
    (haddr[7:0] == `CPSC_OFS_SHIFT) ? {21'h0, shift_q} :
    (haddr[7:0] == `CPSC_OFS_LEVELS) ? levels_w :
    (haddr[7:0] == `CPSC_OFS_PROT) ? {24'h0, current_limit_on, ovl_s} :
    (haddr[7:0] == `CPSC_OFS_LATCHES) ? {24'h0, latches_q} :
    32'h0000_0000;

  // unmapped or upper addresses read zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ap_take && !hwrite && haddr[31:8] == 24'h000000)
      hrdata <= rd_mux;
    else if (ap_take)
      hrdata <= 32'h0000_0000;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule
`default_nettype wire

// [tb/cpsc_properties.sv]
// concurrent checks on the card power switch control pins
`timescale 1ns/10ps
`default_nettype none
module cpsc_properties (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins
  input wire logic serial_latch,
  input wire logic reset_hi,
  input wire logic reset_pin_n,
  input wire logic low_power_limit_n,
  input wire logic [3:0] overload_sense,
  input wire logic overtemp,
  // supplies and switches
  input var cpsc_pkg::cpsc_level_e slot_a_primary_supply,
  input var cpsc_pkg::cpsc_level_e slot_a_program_supply,
  input var cpsc_pkg::cpsc_level_e slot_b_primary_supply,
  input var cpsc_pkg::cpsc_level_e slot_b_program_supply,
  input wire logic discharge_switch_one,
  input wire logic discharge_switch_four,
  input wire logic discharge_switch_seven,
  input wire logic discharge_switch_eleven,
  // protection
  input wire logic [3:0] current_limit_on,
  input wire logic reduced_limit,
  input wire logic overload_flag_n
);
  import cpsc_pkg::*;
  logic [3:0] lat_age_q;
  logic lat_q;
  wire logic rst_any = reset_hi || !reset_pin_n;
  wire logic sw_all = discharge_switch_one && discharge_switch_four
    && discharge_switch_seven && discharge_switch_eleven;
  wire logic all_hiz = slot_a_primary_supply == LVL_HIZ && slot_a_program_supply == LVL_HIZ
    && slot_b_primary_supply == LVL_HIZ && slot_b_program_supply == LVL_HIZ;
  wire logic all_dis = slot_a_primary_supply == LVL_DISCH && slot_a_program_supply == LVL_DISCH
    && slot_b_primary_supply == LVL_DISCH && slot_b_program_supply == LVL_DISCH;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================
  // cycles since the latch pin rose, saturating
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lat_q <= 1'b0;
      lat_age_q <= 4'hF;
    end
    else
    begin
      lat_q <= serial_latch;
      if (serial_latch && !lat_q)
        lat_age_q <= 4'h0;
      else if (lat_age_q != 4'hF)
        lat_age_q <= lat_age_q + 4'h1;
    end
  end
  // ==========================================
  // properties
  AST_RST_DISCH: assert property (rst_any [*4] |=> ##[0:3] sw_all)
    else $error("reset pin left discharge switches open");
  AST_DISCH_SET: assert property (discharge_switch_one |-> sw_all && all_dis)
    else $error("discharge state incomplete");
  AST_DISCH_EXIT: assert property ($fell(sw_all) |-> !rst_any && lat_age_q < 4'hC)
    else $error("discharge left without a fresh latch");
  AST_OT_OFF: assert property (overtemp [*6] |=> all_hiz || discharge_switch_one)
    else $error("outputs on during overtemperature");
  AST_OT_FLAG: assert property (overtemp [*6] |=> !overload_flag_n)
    else $error("overtemperature not flagged");
  AST_LOW_POWER_LIMIT_N_ON: assert property (!low_power_limit_n [*6] |=> reduced_limit)
    else $error("standby without reduced limit");
  AST_LOW_POWER_LIMIT_N_OFF: assert property (low_power_limit_n [*6] |=> !reduced_limit)
    else $error("reduced limit outside standby");
  AST_LIM_FLAG: assert property (current_limit_on != 4'h0 |-> ##[0:2] !overload_flag_n)
    else $error("limiting output not flagged");
  AST_LIM_NONE: assert property (overload_sense == 4'h0 [*6] |=> current_limit_on == 4'h0)
    else $error("limit active without overload");
  cover property (slot_a_program_supply == LVL_V12);
  cover property (current_limit_on != 4'h0);
  cover property (reduced_limit && !overload_flag_n);
endmodule
bind cpsc_top cpsc_properties u_props (
  .hclk, .hresetn, .serial_latch, .reset_hi, .reset_pin_n, .low_power_limit_n,
  .overload_sense, .overtemp, .slot_a_primary_supply, .slot_a_program_supply,
  .slot_b_primary_supply, .slot_b_program_supply, .discharge_switch_one,
  .discharge_switch_four, .discharge_switch_seven, .discharge_switch_eleven,
  .current_limit_on, .reduced_limit, .overload_flag_n
);
`default_nettype wire

// [tb/cpsc_host_ctl.sv]
// behavioural serial controller on the three-wire control link
`timescale 1ns/10ps
`default_nettype none
module cpsc_host_ctl (
  // request from the bench
  input wire logic go,
  input wire logic slow,
  input wire logic [10:0] word,
  output logic busy,
  // three-wire link
  output logic serial_clk,
  output logic serial_data,
  output logic serial_latch
);
  initial
  begin
    busy = 1'b0;
    serial_clk = 1'b0;
    serial_data = 1'b0;
    serial_latch = 1'b0;
  end
  // ==========================================
  // one frame, high bit first; clock stands low between frames
  always @(posedge go)
  begin
    busy = 1'b1;
    // keep link edges clear of the sampling clock edges
    #5;
    for (int i = 10; i >= 0; i--)
    begin
      serial_data = word[i];
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
    end
    // released data line shows the inverse, not a held copy
    serial_data = ~word[0];
    #(slow ? 400 : 20) serial_latch = 1'b1;
    #80 serial_latch = 1'b0;
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// [tb/tb_cpsc_top.sv]
// self-checking bench for the card power switch control
`timescale 1ns/10ps
`default_nettype none
module tb_cpsc_top;
  import cpsc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0, hreadyout, hresp;
  logic reset_hi = 1'b0, reset_pin_n = 1'b1, low_power_limit_n = 1'b1, mode_sel = 1'b0;
  logic [3:0] overload_sense = 4'h0, current_limit_on;
  logic overtemp = 1'b0, go = 1'b0, slow = 1'b0, busy;
  logic [10:0] word = 11'h000;
  logic serial_clk, serial_data, serial_latch, reduced_limit, overload_flag_n;
  logic dsw1, dsw4, dsw7, dsw11;
  cpsc_level_e a_pri, a_prg, b_pri, b_prg;
  int n_errors = 0, checked = 0;
  localparam logic [23:0] DEC_TBL [5] = '{
    {1'b0, 11'h5AA, LVL_V5, LVL_V5, LVL_V33, LVL_V33},
    {1'b1, 11'h5AA, LVL_V5, LVL_V33, LVL_V33, LVL_V5},
    {1'b0, 11'h143, LVL_GND, LVL_HIZ, LVL_V5, LVL_GND},
    {1'b1, 11'h1D5, LVL_V33, LVL_V12, LVL_GND, LVL_V12},
    {1'b1, 11'h0D5, LVL_HIZ, LVL_HIZ, LVL_HIZ, LVL_HIZ}};
  always #10 hclk = ~hclk;
  cpsc_top dut (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .serial_clk, .serial_data,
    .serial_latch, .reset_hi, .reset_pin_n, .low_power_limit_n, .mode_sel,
    .overload_sense, .overtemp, .slot_a_primary_supply(a_pri),
    .slot_a_program_supply(a_prg), .slot_b_primary_supply(b_pri),
    .slot_b_program_supply(b_prg), .discharge_switch_one(dsw1),
    .discharge_switch_four(dsw4), .discharge_switch_seven(dsw7),
    .discharge_switch_eleven(dsw11), .current_limit_on, .reduced_limit, .overload_flag_n);
  cpsc_host_ctl host (.go, .slow, .word, .busy, .serial_clk, .serial_data, .serial_latch);
  // ==========================================
  // shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic chk_val(input logic [31:0] act, input logic [31:0] exp);
    checked++;
    if (act !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, act, exp);
    end
  endtask
  task automatic chk_sup(input logic [11:0] exp);
    chk_val({20'h0, a_pri, a_prg, b_pri, b_prg}, {20'h0, exp});
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk_val(d, e);
    chk_val(hresp, 1'b0);
  endtask
  // frame time plus settle; outputs follow a few cycles after the latch
  task automatic send(input logic [10:0] w);
    word <= w;
    go <= 1'b1;
    cyc(2);
    go <= 1'b0;
    repeat (300) if (busy) @(posedge hclk);
    chk_val(busy, 1'b0);
    cyc(8);
  endtask
  // ==========================================
  // scenarios
  task automatic t_power_up;
    logic [31:0] d;
    chk_sup({4{LVL_DISCH}});
    chk_val({dsw1, dsw4, dsw7, dsw11}, 4'hF);
    rd_chk(32'h00, 32'h2);
    ahb(1'b1, 32'h00, 32'h0, d);
    rd_chk(32'h00, 32'h0);
    ahb(1'b1, 32'h00, 32'h2, d);
    ahb(1'b1, 32'h08, 32'h7FF, d);
    rd_chk(32'h08, 32'h0);
    rd_chk(32'h40, 32'h0);
  endtask
  task automatic t_decode;
    foreach (DEC_TBL[i])
    begin
      mode_sel <= DEC_TBL[i][23];
      slow <= (i == 2);
      send(DEC_TBL[i][22:12]);
      chk_sup(DEC_TBL[i][11:0]);
    end
    chk_val({dsw1, dsw4, dsw7, dsw11}, 4'h0);
    rd_chk(32'h08, 32'h0D5);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    mode_sel <= 1'b0;
    reset_hi <= 1'b1;
    cyc(8);
    chk_val({dsw1, dsw4, dsw7, dsw11}, 4'hF);
    chk_sup({4{LVL_DISCH}});
    send(11'h5AA);
    rd_chk(32'h08, 32'h0D5);
    reset_hi <= 1'b0;
    cyc(10);
    chk_sup({4{LVL_DISCH}});
    send(11'h5AA);
    chk_sup({LVL_V5, LVL_V5, LVL_V33, LVL_V33});
    reset_pin_n <= 1'b0;
    cyc(8);
    chk_sup({4{LVL_DISCH}});
    reset_pin_n <= 1'b1;
    // soft reset from the control register acts like a reset pin
    ahb(1'b1, 32'h00, 32'h3, d);
    cyc(6);
    chk_val({dsw1, dsw4, dsw7, dsw11}, 4'hF);
    ahb(1'b1, 32'h00, 32'h2, d);
    send(11'h5AA);
  endtask
  task automatic t_standby;
    cyc(20);
    chk_sup({LVL_V5, LVL_V5, LVL_V33, LVL_V33});
    // outputs settled before standby is entered
    low_power_limit_n <= 1'b0;
    cyc(6);
    chk_val({reduced_limit, overload_flag_n}, 2'h3);
    send(11'h143);
    chk_val(overload_flag_n, 1'b0);
    rd_chk(32'h04, 32'h97);
    low_power_limit_n <= 1'b1;
    cyc(6);
    chk_val({reduced_limit, overload_flag_n}, 2'h1);
  endtask
  task automatic t_protect;
    overload_sense <= 4'h5;
    cyc(6);
    chk_val({current_limit_on, overload_flag_n}, 5'h08);
    overload_sense <= 4'h0;
    overtemp <= 1'b1;
    cyc(6);
    chk_sup({4{LVL_HIZ}});
    chk_val({current_limit_on, overload_flag_n}, 5'h00);
    overtemp <= 1'b0;
    cyc(6);
    chk_sup({LVL_GND, LVL_HIZ, LVL_V5, LVL_GND});
  endtask
  task automatic finish_test;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // main sequence and watchdog
  initial
  begin
    cyc(5);
    hresetn <= 1'b1;
    cyc(1);
    t_power_up();
    t_decode();
    t_reset();
    t_standby();
    t_protect();
    finish_test();
  end
  initial
  begin
    #200us;
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
